// ==== core/addc_regs.sv ====
// diagnostic, modulator delay and chop control registers with decoded outputs
//
// How it works
// RULE1 - Select 000 is off, 011 near plus full scale, 100 near minus full scale, 101 near zero.
// RULE2 - The diagnostic mux register holds group A select in bits 2:0 and group B in bits 6:4.
// RULE3 - Each channel takes its voltage from the group A or B field by its group assignment.
// RULE4 - Software sets all receive-select bits before it programs the two group select fields; the bench writes 0x57 before its first write to 0x56.
// RULE5 - The diagnostic mux register at 0x57 resets to zero, so no test voltage is applied.
// RULE6 - Delayed clock field 3:2 is 00 none, 01 channels 0-1, 10 channels 2-3, 11 all.
// RULE7 - The delay register low pair resets to 10 and software always writes 10 there.
// RULE8 - The modulator delay register at 0x58 resets to 0x02, delayed clock off everywhere.
// RULE9 - Chop A is bits 3:2, B bits 1:0, and code 01 chops at one eighth of the modulator rate.
// RULE10 - Chop code 10 chops at one thirty-second of the modulator rate for either group.
// RULE11 - The chop control register at 0x59 resets to 0x0A, both groups at the slower rate.
// RULE12 - Software writes no unlisted field codes; their effect is undefined. The bench writes 0xFF to 0x57, select code 111 in both fields.
// RULE13 - Register 0x56 has a receive bit per channel, and only a set bit lets a voltage in.
// RULE14 - Software enables input precharge buffers on every channel that takes a test voltage.
module addc_regs
(
  input  wire  logic                                       clk,
  input  wire  logic                                       nrst,
  input  wire  logic                                       reg_wr,
  input  wire  logic                                       reg_rd,
  input  wire  logic [7:0]                                 reg_addr,
  input  wire  logic [7:0]                                 reg_wdata,
  input  wire  logic [addc_pkg::NUM_CH-1:0]                channel_group_b,
  output logic [7:0]                                       reg_rdata,
  output logic                                             reg_rvalid,
  output addc_pkg::addc_diag_t [addc_pkg::NUM_CH-1:0]      channel_diag_voltage,
  output logic [addc_pkg::NUM_CH-1:0]                      delayed_sampling_clock_select,
  output addc_pkg::addc_chop_t                             group_a_chop_rate,
  output addc_pkg::addc_chop_t                             group_b_chop_rate
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]                                  rx;
    logic [7:0]                                  mux;
    logic [7:0]                                  delay;
    logic [7:0]                                  chop;
    logic [7:0]                                  rdata;
    logic                                        rvalid;
    addc_pkg::addc_diag_t [addc_pkg::NUM_CH-1:0] diag;
    logic [addc_pkg::NUM_CH-1:0]                 del_en;
    addc_pkg::addc_chop_t                        chop_a;
    addc_pkg::addc_chop_t                        chop_b;
    logic                                        mux_written;
    logic                                        delay_written;
    logic                                        chop_written;
  } addc_state_t;

  localparam addc_state_t RESET_STATE = '{
    rx:            addc_pkg::RST_DIAG_RX,
    mux:           addc_pkg::RST_DIAG_MUX,
    delay:         addc_pkg::RST_MOD_DELAY,
    chop:          addc_pkg::RST_CHOP,
    rdata:         addc_pkg::READ_UNMAPPED,
    rvalid:        1'b0,
    diag:          '{default: addc_pkg::DIAG_OFF},
    del_en:        '0,
    chop_a:        addc_pkg::CHOP_MOD_DIV32,
    chop_b:        addc_pkg::CHOP_MOD_DIV32,
    mux_written:   1'b0,
    delay_written: 1'b0,
    chop_written:  1'b0
  };

  addc_state_t st;
  addc_state_t next_st;
  addc_route_if rif ();

  assign rif.rx      = st.rx;
  assign rif.mux     = st.mux;
  assign rif.delay   = st.delay;
  assign rif.chop    = st.chop;
  assign rif.group_b = channel_group_b;

  addc_route u_route
  (
    .rif (rif)
  );

  // ----------------------------------------------------------------
  // register access and output staging
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st        = st;
    next_st.rvalid = reg_rd;
    // a read in the same cycle as a write returns the old value
    if (reg_rd)
    begin
      case (reg_addr)
        addc_pkg::ADDR_DIAG_RX:   next_st.rdata = st.rx;
        addc_pkg::ADDR_DIAG_MUX:  next_st.rdata = st.mux;
        addc_pkg::ADDR_MOD_DELAY: next_st.rdata = st.delay;
        addc_pkg::ADDR_CHOP:      next_st.rdata = st.chop;
        default:                  next_st.rdata = addc_pkg::READ_UNMAPPED;
      endcase
    end
    if (reg_wr)
    begin
      case (reg_addr)
        addc_pkg::ADDR_DIAG_RX:
        begin
          next_st.rx = reg_wdata & addc_pkg::MASK_DIAG_RX; // [RULE13]
        end
        addc_pkg::ADDR_DIAG_MUX:
        begin
          next_st.mux         = reg_wdata & addc_pkg::MASK_DIAG_MUX; // [RULE2]
          next_st.mux_written = 1'b1;
        end
        addc_pkg::ADDR_MOD_DELAY:
        begin
          // low pair stored as written; software keeps it at its fixed value
          next_st.delay         = reg_wdata & addc_pkg::MASK_MOD_DELAY; // [RULE7]
          next_st.delay_written = 1'b1;
        end
        addc_pkg::ADDR_CHOP:
        begin
          next_st.chop         = reg_wdata & addc_pkg::MASK_CHOP; // [RULE9]
          next_st.chop_written = 1'b1;
        end
        default:
        begin
          next_st.rx = st.rx;
        end
      endcase
    end
    // registered so every output comes from a flop, one cycle behind the fields
    next_st.diag   = rif.diag; // [RULE1] [RULE3]
    next_st.del_en = rif.del_en; // [RULE6]
    next_st.chop_a = rif.chop_a; // [RULE10]
    next_st.chop_b = rif.chop_b; // [RULE10]
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st <= RESET_STATE; // [RULE5] [RULE8] [RULE11]
    end
    else
    begin
      st <= next_st;
    end
  end

  assign reg_rdata                     = st.rdata;
  assign reg_rvalid                    = st.rvalid;
  assign channel_diag_voltage          = st.diag;
  assign delayed_sampling_clock_select = st.del_en;
  assign group_a_chop_rate             = st.chop_a;
  assign group_b_chop_rate             = st.chop_b;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence mux_write_s;
    reg_wr && (reg_addr == addc_pkg::ADDR_DIAG_MUX);
  endsequence

  sequence chop_read_s;
    reg_rd && (reg_addr == addc_pkg::ADDR_CHOP);
  endsequence

  sequence ch0_pos_s;
    st.rx[addc_pkg::RX_BIT[0]] && !channel_group_b[0] &&
    (st.mux[addc_pkg::SEL_A_LSB +: addc_pkg::SEL_W] == addc_pkg::SEL_POS_FS);
  endsequence

  sequence ch2_zero_s;
    st.rx[addc_pkg::RX_BIT[2]] && channel_group_b[2] &&
    (st.mux[addc_pkg::SEL_B_LSB +: addc_pkg::SEL_W] == addc_pkg::SEL_ZERO);
  endsequence

  sequence ch1_neg_s;
    st.rx[addc_pkg::RX_BIT[1]] && !channel_group_b[1] &&
    (st.mux[addc_pkg::SEL_A_LSB +: addc_pkg::SEL_W] == addc_pkg::SEL_NEG_FS);
  endsequence

  // decoded outputs trail the fields by one edge, hence |=> or ##1 before every output check
  mux_reset_a: assert property (!st.mux_written |-> st.mux == addc_pkg::RST_DIAG_MUX) // [RULE5]
    else $error("diag mux left its reset value without a write");
  mux_write_a: assert property (mux_write_s |=> // [RULE2]
      st.mux == ($past(reg_wdata) & addc_pkg::MASK_DIAG_MUX))
    else $error("diag mux write not stored in its fields");
  rx_write_a: assert property (reg_wr && reg_addr == addc_pkg::ADDR_DIAG_RX |=> // [RULE13]
      st.rx == ($past(reg_wdata) & addc_pkg::MASK_DIAG_RX))
    else $error("receive select write not stored per channel");
  pos_decode_a: assert property (ch0_pos_s |=> // [RULE1]
      channel_diag_voltage[0] == addc_pkg::DIAG_POS_FS)
    else $error("channel 0 missed the positive full scale select");
  neg_decode_a: assert property (ch1_neg_s |=> // [RULE1]
      channel_diag_voltage[1] == addc_pkg::DIAG_NEG_FS)
    else $error("channel 1 missed the negative full scale select");
  group_route_a: assert property (ch2_zero_s |=> // [RULE3]
      channel_diag_voltage[2] == addc_pkg::DIAG_ZERO)
    else $error("channel 2 did not follow the group B select");
  rx_gate_a: assert property (!st.rx[addc_pkg::RX_BIT[3]] |=> // [RULE13]
      channel_diag_voltage[3] == addc_pkg::DIAG_OFF)
    else $error("channel 3 got a voltage with receive off");
  del_none_a: assert property ( // [RULE6]
      st.delay[addc_pkg::DEL_LSB +: addc_pkg::DEL_W] == addc_pkg::DEL_NONE
      |=> delayed_sampling_clock_select == 4'h0)
    else $error("delayed clock on with the field disabled");
  del_pair_a: assert property ( // [RULE6]
      st.delay[addc_pkg::DEL_LSB +: addc_pkg::DEL_W] == addc_pkg::DEL_CH01
      |=> delayed_sampling_clock_select == 4'h3)
    else $error("delayed clock not limited to channels 0 and 1");
  del_high_a: assert property ( // [RULE6]
      st.delay[addc_pkg::DEL_LSB +: addc_pkg::DEL_W] == addc_pkg::DEL_CH23
      |=> delayed_sampling_clock_select == 4'hC)
    else $error("delayed clock not limited to channels 2 and 3");
  del_all_a: assert property ( // [RULE6]
      st.delay[addc_pkg::DEL_LSB +: addc_pkg::DEL_W] == addc_pkg::DEL_ALL
      |=> delayed_sampling_clock_select == 4'hF)
    else $error("delayed clock missing on some channel");
  delay_reset_a: assert property ( // [RULE8]
      !st.delay_written |-> st.delay == addc_pkg::RST_MOD_DELAY)
    else $error("modulator delay left its reset value without a write");
  delay_fix_a: assert property (!st.delay_written |-> // [RULE7]
      st.delay[addc_pkg::DEL_FIX_LSB +: addc_pkg::DEL_FIX_W] == addc_pkg::DEL_FIX)
    else $error("modulator delay low pair not at its fixed value");
  chop_write_a: assert property (reg_wr && reg_addr == addc_pkg::ADDR_CHOP |=> // [RULE9]
      st.chop == ($past(reg_wdata) & addc_pkg::MASK_CHOP))
    else $error("chop control write not stored in its fields");
  chop_fast_a: assert property ( // [RULE9]
      st.chop[addc_pkg::CHOP_A_LSB +: addc_pkg::CHOP_W] == addc_pkg::CHOP_DIV8
      |=> group_a_chop_rate == addc_pkg::CHOP_MOD_DIV8)
    else $error("group A chop rate not one eighth");
  chop_slow_a: assert property ( // [RULE10]
      st.chop[addc_pkg::CHOP_B_LSB +: addc_pkg::CHOP_W] == addc_pkg::CHOP_DIV32
      |=> group_b_chop_rate == addc_pkg::CHOP_MOD_DIV32)
    else $error("group B chop rate not one thirty-second");
  chop_reset_a: assert property ( // [RULE11]
      !st.chop_written |-> st.chop == addc_pkg::RST_CHOP ##1
      group_a_chop_rate == addc_pkg::CHOP_MOD_DIV32)
    else $error("chop control reset value wrong");
  chop_read_a: assert property (chop_read_s |=> // [RULE9]
      reg_rvalid && reg_rdata == $past(st.chop))
    else $error("chop control readback wrong");

endmodule

// ==== core/addc_pkg.sv ====
// constants and types shared by the diagnostic, delay and chop register bank
package addc_pkg;

  // ----------------------------------------------------------------
  // register offsets on the control port
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_DIAG_RX   = 8'h56;
  localparam logic [7:0] ADDR_DIAG_MUX  = 8'h57;
  localparam logic [7:0] ADDR_MOD_DELAY = 8'h58;
  localparam logic [7:0] ADDR_CHOP      = 8'h59;

  // ----------------------------------------------------------------
  // reset values and implemented-bit masks
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_DIAG_RX    = 8'h00;
  localparam logic [7:0] RST_DIAG_MUX   = 8'h00;
  localparam logic [7:0] RST_MOD_DELAY  = 8'h02;
  localparam logic [7:0] RST_CHOP       = 8'h0A;
  localparam logic [7:0] MASK_DIAG_RX   = 8'h33;
  localparam logic [7:0] MASK_DIAG_MUX  = 8'h77;
  localparam logic [7:0] MASK_MOD_DELAY = 8'h0F;
  localparam logic [7:0] MASK_CHOP      = 8'h0F;
  localparam logic [7:0] READ_UNMAPPED  = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int NUM_CH       = 4;
  localparam int SEL_W        = 3;
  localparam int SEL_A_LSB    = 0;
  localparam int SEL_B_LSB    = 4;
  localparam int DEL_W        = 2;
  localparam int DEL_LSB      = 2;
  localparam int DEL_FIX_W    = 2;
  localparam int DEL_FIX_LSB  = 0;
  localparam int CHOP_W       = 2;
  localparam int CHOP_A_LSB   = 2;
  localparam int CHOP_B_LSB   = 0;
  localparam int RX_BIT [0:NUM_CH-1] = '{0, 1, 4, 5};
  localparam int LOW_PAIR     = 2;

  // ----------------------------------------------------------------
  // field codes
  // ----------------------------------------------------------------
  localparam logic [SEL_W-1:0]  SEL_OFF    = 3'h0;
  localparam logic [SEL_W-1:0]  SEL_POS_FS = 3'h3;
  localparam logic [SEL_W-1:0]  SEL_NEG_FS = 3'h4;
  localparam logic [SEL_W-1:0]  SEL_ZERO   = 3'h5;
  localparam logic [DEL_W-1:0]  DEL_NONE   = 2'h0;
  localparam logic [DEL_W-1:0]  DEL_CH01   = 2'h1;
  localparam logic [DEL_W-1:0]  DEL_CH23   = 2'h2;
  localparam logic [DEL_W-1:0]  DEL_ALL    = 2'h3;
  localparam logic [DEL_FIX_W-1:0] DEL_FIX = 2'h2;
  localparam logic [CHOP_W-1:0] CHOP_DIV8  = 2'h1;
  localparam logic [CHOP_W-1:0] CHOP_DIV32 = 2'h2;

  typedef enum logic [1:0] {
    DIAG_OFF,
    DIAG_POS_FS,
    DIAG_NEG_FS,
    DIAG_ZERO
  } addc_diag_t;

  typedef enum logic [1:0] {
    CHOP_RSVD,
    CHOP_MOD_DIV8,
    CHOP_MOD_DIV32
  } addc_chop_t;

endpackage

// ==== core/addc_route_if.sv ====
// register contents out to the channel router and decoded settings back
interface addc_route_if;
  logic [7:0]                                rx;
  logic [7:0]                                mux;
  logic [7:0]                                delay;
  logic [7:0]                                chop;
  logic [addc_pkg::NUM_CH-1:0]               group_b;
  addc_pkg::addc_diag_t [addc_pkg::NUM_CH-1:0] diag;
  logic [addc_pkg::NUM_CH-1:0]               del_en;
  addc_pkg::addc_chop_t                      chop_a;
  addc_pkg::addc_chop_t                      chop_b;

  modport regs  (output rx, mux, delay, chop, group_b, input diag, del_en, chop_a, chop_b);
  modport route (input rx, mux, delay, chop, group_b, output diag, del_en, chop_a, chop_b);
endinterface

// ==== core/addc_route.sv ====
// per-channel decode of diagnostic and delayed clock settings, per-group decode of chop settings
module addc_route
(
  addc_route_if.route rif
);

  function automatic addc_pkg::addc_diag_t addc_decode_sel(input logic [addc_pkg::SEL_W-1:0] s);
    case (s)
      addc_pkg::SEL_POS_FS: addc_decode_sel = addc_pkg::DIAG_POS_FS;
      addc_pkg::SEL_NEG_FS: addc_decode_sel = addc_pkg::DIAG_NEG_FS;
      addc_pkg::SEL_ZERO:   addc_decode_sel = addc_pkg::DIAG_ZERO;
      // off and unlisted codes apply no voltage
      default:              addc_decode_sel = addc_pkg::DIAG_OFF;
    endcase
  endfunction

  function automatic addc_pkg::addc_chop_t addc_decode_chop(input logic [addc_pkg::CHOP_W-1:0] c);
    case (c)
      addc_pkg::CHOP_DIV8:  addc_decode_chop = addc_pkg::CHOP_MOD_DIV8;
      addc_pkg::CHOP_DIV32: addc_decode_chop = addc_pkg::CHOP_MOD_DIV32;
      default:              addc_decode_chop = addc_pkg::CHOP_RSVD;
    endcase
  endfunction

  logic [addc_pkg::SEL_W-1:0] sel_a;
  logic [addc_pkg::SEL_W-1:0] sel_b;
  logic [addc_pkg::DEL_W-1:0] del_field;

  assign sel_a     = rif.mux[addc_pkg::SEL_A_LSB +: addc_pkg::SEL_W];
  assign sel_b     = rif.mux[addc_pkg::SEL_B_LSB +: addc_pkg::SEL_W];
  assign del_field = rif.delay[addc_pkg::DEL_LSB +: addc_pkg::DEL_W];

  logic [addc_pkg::CHOP_W-1:0] chop_a_field;
  logic [addc_pkg::CHOP_W-1:0] chop_b_field;

  assign chop_a_field = rif.chop[addc_pkg::CHOP_A_LSB +: addc_pkg::CHOP_W]; // [RULE9]
  assign chop_b_field = rif.chop[addc_pkg::CHOP_B_LSB +: addc_pkg::CHOP_W]; // [RULE9]
  assign rif.chop_a   = addc_decode_chop(chop_a_field); // [RULE9] [RULE10]
  assign rif.chop_b   = addc_decode_chop(chop_b_field); // [RULE9] [RULE10]

  for (genvar ch = 0; ch < addc_pkg::NUM_CH; ch++)
  begin : g_ch
    logic [addc_pkg::SEL_W-1:0] sel;
    logic                       pair_on;

    assign sel = rif.group_b[ch] ? sel_b : sel_a; // [RULE3]
    assign rif.diag[ch] = rif.rx[addc_pkg::RX_BIT[ch]] ? addc_decode_sel(sel) // [RULE13] [RULE1]
                                                       : addc_pkg::DIAG_OFF;
    assign pair_on = (ch < addc_pkg::LOW_PAIR) ? (del_field == addc_pkg::DEL_CH01)
                                               : (del_field == addc_pkg::DEL_CH23);
    assign rif.del_en[ch] = pair_on || (del_field == addc_pkg::DEL_ALL); // [RULE6]
  end

endmodule

// ==== sim/addc_tb.sv ====
// self-checking bench for the diagnostic, delay and chop register bank
module tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic                                        clk;
  logic                                        nrst;
  logic                                        reg_wr;
  logic                                        reg_rd;
  logic [7:0]                                  reg_addr;
  logic [7:0]                                  reg_wdata;
  logic [addc_pkg::NUM_CH-1:0]                 channel_group_b;
  logic [7:0]                                  reg_rdata;
  logic                                        reg_rvalid;
  addc_pkg::addc_diag_t [addc_pkg::NUM_CH-1:0] channel_diag_voltage;
  logic [addc_pkg::NUM_CH-1:0]                 delayed_sampling_clock_select;
  addc_pkg::addc_chop_t                        group_a_chop_rate;
  addc_pkg::addc_chop_t                        group_b_chop_rate;
  int                                          errors;
  int                                          n_tests;
  logic [7:0]                                  exp_q [$];
  logic [7:0]                                  sh_rx, sh_mux, sh_del, sh_chop;
  logic [2:0]                                  codes [4] = '{3'h0, 3'h3, 3'h4, 3'h5};

  addc_regs addc_regs_inst (.clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .channel_group_b(channel_group_b),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .channel_diag_voltage(channel_diag_voltage),
    .delayed_sampling_clock_select(delayed_sampling_clock_select),
    .group_a_chop_rate(group_a_chop_rate), .group_b_chop_rate(group_b_chop_rate));

  initial clk = 1'b0;
  always #5 clk = ~clk;

  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch at %0t exp %0h got %0h", $time, e, g);
    end
  endtask

  // ----------------------------------------------------------------
  // read result monitor
  // ----------------------------------------------------------------
  // falling edge: read results are settled half a cycle after launch
  always @(negedge clk)
  begin
    if (reg_rvalid === 1'b1)
    begin
      if (exp_q.size() == 0)
      begin
        errors++;
        $display("mismatch at %0t exp none got %0h", $time, reg_rdata);
      end
      else
      begin
        chk(exp_q.pop_front(), reg_rdata);
      end
    end
  end

  // ----------------------------------------------------------------
  // drivers and expectations
  // ----------------------------------------------------------------
  task automatic cyc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    reg_wr = w;
    reg_rd = r;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #1;
  endtask

  task automatic idle(input int n);
    repeat (n) cyc(1'b0, 1'b0, 8'h00, 8'h00);
  endtask

  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    cyc(1'b0, 1'b1, a, 8'h00);
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    if (a == addc_pkg::ADDR_DIAG_RX) sh_rx = d & addc_pkg::MASK_DIAG_RX;
    if (a == addc_pkg::ADDR_DIAG_MUX) sh_mux = d & addc_pkg::MASK_DIAG_MUX;
    if (a == addc_pkg::ADDR_MOD_DELAY) sh_del = d & addc_pkg::MASK_MOD_DELAY;
    if (a == addc_pkg::ADDR_CHOP) sh_chop = d & addc_pkg::MASK_CHOP;
    cyc(1'b1, 1'b0, a, d);
  endtask

  task automatic rback();
    rreg(8'h56, sh_rx);
    rreg(8'h57, sh_mux);
    rreg(8'h58, sh_del);
    rreg(8'h59, sh_chop);
  endtask

  function automatic addc_pkg::addc_diag_t dec(input logic [2:0] s);
    case (s)
      3'h3:    return addc_pkg::DIAG_POS_FS;
      3'h4:    return addc_pkg::DIAG_NEG_FS;
      3'h5:    return addc_pkg::DIAG_ZERO;
      default: return addc_pkg::DIAG_OFF;
    endcase
  endfunction

  function automatic addc_pkg::addc_chop_t chp(input logic [1:0] c);
    return (c == 2'h1) ? addc_pkg::CHOP_MOD_DIV8 :
           (c == 2'h2) ? addc_pkg::CHOP_MOD_DIV32 : addc_pkg::CHOP_RSVD;
  endfunction

  task automatic chk_out();
    logic [2:0]           s;
    addc_pkg::addc_diag_t e;
    for (int i = 0; i < addc_pkg::NUM_CH; i++)
    begin
      s = channel_group_b[i] ? sh_mux[6:4] : sh_mux[2:0];
      e = sh_rx[addc_pkg::RX_BIT[i]] ? dec(s) : addc_pkg::DIAG_OFF;
      chk(8'(e), 8'(channel_diag_voltage[i]));
      chk(8'(sh_del[2 + i / 2]), 8'(delayed_sampling_clock_select[i]));
    end
    chk(8'(chp(sh_chop[3:2])), 8'(group_a_chop_rate));
    chk(8'(chp(sh_chop[1:0])), 8'(group_b_chop_rate));
  endtask

  task automatic results();
    if (exp_q.size() != 0) errors++;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
    begin
      $display("STATUS OK");
    end
    else
    begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial
  begin
    errors = 0;
    n_tests = 0;
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    channel_group_b = 4'h0;
    {sh_rx, sh_mux, sh_del, sh_chop} = 32'h0000_020A;
    void'($urandom(10949));
    repeat (5) @(posedge clk);
    #1;
    nrst = 1'b1;
    rreg(8'h57, 8'h00);
    rreg(8'h58, 8'h02);
    rreg(8'h59, 8'h0A);
    rreg(8'h5A, 8'h00);
    idle(2);
    chk_out();
    $display("test reset values done");
    wreg(8'h5A, 8'hFF);
    wreg(8'h57, 8'hFF);
    rreg(8'h57, 8'h77);
    rreg(8'h5A, 8'h00);
    // receive bits all set before the loop picks any listed select code
    // precharge buffers sit outside this block; the host owns them
    wreg(8'h56, 8'hFF);
    // only listed codes are written
    for (int k = 0; k < 22; k++)
    begin
      if (k >= 16) wreg(8'h56, 8'($urandom));
      wreg(8'h57, {1'b0, codes[k % 4], 1'b0, codes[(k / 4) % 4]});
      channel_group_b = 4'($urandom);
      idle(3);
      chk_out();
    end
    $display("test diagnostic select done");
    for (int c = 0; c < 4; c++)
    begin
      wreg(8'h58, {4'h0, 2'(c), 2'b10});
      idle(3);
      chk_out();
    end
    $display("test delayed clock done");
    for (int c = 0; c < 4; c++)
    begin
      wreg(8'h59, {4'h0, 2'(c / 2 + 1), 2'(c % 2 + 1)});
      idle(3);
      chk_out();
    end
    exp_q.push_back(sh_chop);
    sh_chop = 8'h05;
    cyc(1'b1, 1'b1, 8'h59, 8'h05);
    rback();
    idle(3);
    chk_out();
    $display("test chop rate done");
    nrst = 1'b0;
    {sh_rx, sh_mux, sh_del, sh_chop} = 32'h0000_020A;
    idle(2);
    chk_out();
    nrst = 1'b1;
    rback();
    idle(3);
    $display("test mid-run reset done");
    results();
  end

  initial
  begin
    #50000;
    errors++;
    $display("watchdog expired at %0t", $time);
    results();
  end
endmodule
